// *** logic/rxcs_pkg.sv ***
// constants for the receive clock fault squelch register bank
package rxcs_pkg;
  localparam logic [4:0] DEV_ADDR = 5'h1e;

  localparam logic [15:0] OFS_CTRL_A = 16'h800b;
  localparam logic [15:0] OFS_CTRL_B = 16'h800c;
  localparam logic [15:0] OFS_CTRL_C = 16'h800d;
  localparam logic [15:0] OFS_CTRL_D = 16'h800e;
  localparam logic [15:0] OFS_CTRL_E = 16'h800f;
  localparam logic [15:0] OFS_CTRL_F = 16'h8010;
  localparam logic [15:0] OFS_CTRL_G = 16'h8011;
  localparam logic [15:0] OFS_STAT_CLEAR_A = 16'h8012;
  localparam logic [15:0] OFS_STAT_CLEAR_B = 16'h8013;
  localparam logic [15:0] OFS_STAT_LATCH = 16'h8014;
  localparam logic [15:0] OFS_STAT_PLAIN = 16'h8015;
  localparam logic [15:0] OFS_CTRL_H = 16'h8020;
  localparam logic [15:0] OFS_SQUELCH_CTRL = 16'h8021;

  localparam logic [15:0] RST_CTRL_A = 16'h013c;
  localparam logic [15:0] RST_CTRL_B = 16'h01bc;
  localparam logic [15:0] RST_CTRL_C = 16'h01fc;
  localparam logic [15:0] RST_CTRL_G = 16'h7f00;
  localparam logic [15:0] RST_CTRL_H = 16'h0000;
  localparam logic [15:0] RST_STAT_CLEAR = 16'hfffd;
  localparam logic [15:0] RST_SQUELCH_CTRL = 16'h000f;

  localparam logic [15:0] MASK_CTRL_LOW10 = 16'h03ff;
  localparam logic [15:0] MASK_CTRL_G = 16'hff00;
  localparam logic [15:0] MASK_CTRL_H = 16'hffff;
  localparam logic [15:0] MASK_SQUELCH_CTRL = 16'h00ff;

  localparam int FLATLINE_BIT = 3;
  localparam int BUFFER_OFF_BIT = 2;
  localparam int LATCH_FAULT_BIT = 11;
  localparam int LATCH_LOCK_BIT = 8;

  localparam int MEM_DEPTH = 8;
  localparam int MEM_AW = 3;

  // maps a register address to {hit, index} of the control memory
  function automatic logic [MEM_AW:0] mem_index(input logic [15:0] addr);
    case (addr)
      OFS_CTRL_A: mem_index = 4'h8;
      OFS_CTRL_B: mem_index = 4'h9;
      OFS_CTRL_C: mem_index = 4'ha;
      OFS_CTRL_D: mem_index = 4'hb;
      OFS_CTRL_E: mem_index = 4'hc;
      OFS_CTRL_F: mem_index = 4'hd;
      OFS_CTRL_G: mem_index = 4'he;
      OFS_CTRL_H: mem_index = 4'hf;
      default: mem_index = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] mem_reset(input logic [MEM_AW-1:0] idx);
    case (idx)
      3'h0, 3'h3: mem_reset = RST_CTRL_A;
      3'h1, 3'h4: mem_reset = RST_CTRL_B;
      3'h2, 3'h5: mem_reset = RST_CTRL_C;
      3'h6: mem_reset = RST_CTRL_G;
      default: mem_reset = RST_CTRL_H;
    endcase
  endfunction

  function automatic logic [15:0] mem_mask(input logic [MEM_AW-1:0] idx);
    case (idx)
      3'h6: mem_mask = MASK_CTRL_G;
      3'h7: mem_mask = MASK_CTRL_H;
      default: mem_mask = MASK_CTRL_LOW10;
    endcase
  endfunction
endpackage

// *** logic/rxcs_ctrl_mem.sv ***
// small memory holding the plain read-write control words
`timescale 1ns/1ps
module rxcs_ctrl_mem (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [rxcs_pkg::MEM_AW-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [rxcs_pkg::MEM_AW-1:0] rd_idx,
  output logic [15:0] rd_data
);
  typedef struct packed {
    logic [rxcs_pkg::MEM_DEPTH-1:0][15:0] words;
    logic [15:0] rd_data;
  } rxcs_mem_state_t;

  rxcs_mem_state_t s_r;
  rxcs_mem_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // read sees the word as it stood before a same-cycle write
    s_nxt.rd_data = s_r.words[rd_idx];
    if (wr_en) begin
      s_nxt.words[wr_idx] = wr_data & rxcs_pkg::mem_mask(wr_idx);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < rxcs_pkg::MEM_DEPTH; i++) begin
        s_r.words[i] <= rxcs_pkg::mem_reset(i[rxcs_pkg::MEM_AW-1:0]);
      end
      s_r.rd_data <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
endmodule

// *** logic/rxcs_regs.sv ***
// receive clock fault squelch register bank with fault response
//
// Operation
// - flatline bit set: hold clock on fault
// - buffer bit set: power buffer down on fault
// - squelch control resets to 0x000f
// - clear-on-read status resets 0xfffd, read clears
`timescale 1ns/1ps
module rxcs_regs (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [4:0] mgmt_dev_addr,
  input wire logic [15:0] mgmt_reg_addr,
  input wire logic mgmt_wr_en,
  input wire logic [15:0] mgmt_wr_data,
  input wire logic mgmt_rd_en,
  output logic mgmt_rd_valid,
  output logic [15:0] mgmt_rd_data,
  input wire logic high_speed_side_pll_lock,
  input wire logic high_speed_side_loss_of_signal,
  output logic recovered_receive_clock_out_hold,
  output logic recovered_receive_clock_out_buffer_off
);
  typedef struct packed {
    logic [2:0] lock_sync;
    logic [2:0] sig_loss_sync;
    logic lock_f;
    logic sig_loss_f;
    logic [15:0] squelch;
    logic [15:0] stat_a;
    logic [15:0] stat_b;
    logic fault_latch;
    logic hold;
    logic buffer_off;
    logic rd_p1;
    logic rd_mem_p1;
    logic [15:0] rd_own_p1;
    logic rd_valid;
    logic [15:0] rd_data;
  } rxcs_state_t;

  rxcs_state_t s_r;
  rxcs_state_t s_nxt;

  logic dev_hit;
  logic rd_acc;
  logic wr_acc;
  logic [rxcs_pkg::MEM_AW:0] mem_sel;
  logic [15:0] mem_rd_data;
  logic fault;

  assign dev_hit = (mgmt_dev_addr == rxcs_pkg::DEV_ADDR);
  assign rd_acc = mgmt_rd_en & dev_hit;
  assign wr_acc = mgmt_wr_en & dev_hit;
  assign mem_sel = rxcs_pkg::mem_index(mgmt_reg_addr);
  assign fault = ~s_r.lock_f | s_r.sig_loss_f;

  rxcs_ctrl_mem u_mem (
    .clock(clock),
    .nrst(nrst),
    .wr_en(wr_acc & mem_sel[rxcs_pkg::MEM_AW]),
    .wr_idx(mem_sel[rxcs_pkg::MEM_AW-1:0]),
    .wr_data(mgmt_wr_data),
    .rd_idx(mem_sel[rxcs_pkg::MEM_AW-1:0]),
    .rd_data(mem_rd_data)
  );

  always_comb begin
    s_nxt = s_r;
    // pin synchronisers, a change counts once stages two and three agree
    s_nxt.lock_sync = {s_r.lock_sync[1:0], high_speed_side_pll_lock};
    s_nxt.sig_loss_sync = {s_r.sig_loss_sync[1:0], high_speed_side_loss_of_signal};
    if (s_r.lock_sync[1] == s_r.lock_sync[2]) begin
      s_nxt.lock_f = s_r.lock_sync[2];
    end
    if (s_r.sig_loss_sync[1] == s_r.sig_loss_sync[2]) begin
      s_nxt.sig_loss_f = s_r.sig_loss_sync[2];
    end
    // fault response, released as soon as the fault is gone
    s_nxt.hold = fault & s_r.squelch[rxcs_pkg::FLATLINE_BIT];
    s_nxt.buffer_off = fault & s_r.squelch[rxcs_pkg::BUFFER_OFF_BIT];

    if (wr_acc && mgmt_reg_addr == rxcs_pkg::OFS_SQUELCH_CTRL) begin
      s_nxt.squelch = mgmt_wr_data & rxcs_pkg::MASK_SQUELCH_CTRL;
    end

    s_nxt.rd_p1 = rd_acc;
    s_nxt.rd_mem_p1 = rd_acc & mem_sel[rxcs_pkg::MEM_AW];
    s_nxt.rd_own_p1 = 16'h0000;
    if (rd_acc) begin
      case (mgmt_reg_addr)
        rxcs_pkg::OFS_STAT_CLEAR_A: begin
          s_nxt.rd_own_p1 = s_r.stat_a;
          s_nxt.stat_a = 16'h0000;
        end
        rxcs_pkg::OFS_STAT_CLEAR_B: begin
          s_nxt.rd_own_p1 = s_r.stat_b;
          s_nxt.stat_b = 16'h0000;
        end
        rxcs_pkg::OFS_STAT_LATCH: begin
          s_nxt.rd_own_p1[rxcs_pkg::LATCH_FAULT_BIT] = s_r.fault_latch;
          s_nxt.rd_own_p1[rxcs_pkg::LATCH_LOCK_BIT] = s_r.lock_f;
          s_nxt.fault_latch = 1'b0;
        end
        rxcs_pkg::OFS_SQUELCH_CTRL: s_nxt.rd_own_p1 = s_r.squelch;
        default: s_nxt.rd_own_p1 = 16'h0000;
      endcase
    end
    // latched fault: a fault in the clearing cycle survives the read
    if (fault) begin
      s_nxt.fault_latch = 1'b1;
    end

    s_nxt.rd_valid = s_r.rd_p1;
    s_nxt.rd_data = s_r.rd_mem_p1 ? mem_rd_data : s_r.rd_own_p1;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r.lock_sync <= 3'h0;
      s_r.sig_loss_sync <= 3'h0;
      s_r.lock_f <= 1'b0;
      s_r.sig_loss_f <= 1'b0;
      s_r.squelch <= rxcs_pkg::RST_SQUELCH_CTRL;
      s_r.stat_a <= rxcs_pkg::RST_STAT_CLEAR;
      s_r.stat_b <= rxcs_pkg::RST_STAT_CLEAR;
      s_r.fault_latch <= 1'b0;
      s_r.hold <= 1'b0;
      s_r.buffer_off <= 1'b0;
      s_r.rd_p1 <= 1'b0;
      s_r.rd_mem_p1 <= 1'b0;
      s_r.rd_own_p1 <= 16'h0000;
      s_r.rd_valid <= 1'b0;
      s_r.rd_data <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mgmt_rd_valid = s_r.rd_valid;
  assign mgmt_rd_data = s_r.rd_data;
  assign recovered_receive_clock_out_hold = s_r.hold;
  assign recovered_receive_clock_out_buffer_off = s_r.buffer_off;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence lock_lost_s;
    !high_speed_side_pll_lock && s_r.squelch[rxcs_pkg::FLATLINE_BIT] [*6];
  endsequence

  sequence sig_lost_s;
    high_speed_side_loss_of_signal && s_r.squelch[rxcs_pkg::BUFFER_OFF_BIT] [*6];
  endsequence

  sequence link_good_s;
    high_speed_side_pll_lock && !high_speed_side_loss_of_signal [*6];
  endsequence

  chk_flatline_on_lock: assert property (
    lock_lost_s |-> recovered_receive_clock_out_hold)
    else $error("clock not held after lock loss");
  chk_flatline_off_clear: assert property (
    !s_r.squelch[rxcs_pkg::FLATLINE_BIT] |=> !recovered_receive_clock_out_hold)
    else $error("clock held with flatline bit clear");
  chk_buffer_on_loss: assert property (
    sig_lost_s |-> recovered_receive_clock_out_buffer_off)
    else $error("buffer not off after signal loss");
  chk_buffer_off_clear: assert property (
    !s_r.squelch[rxcs_pkg::BUFFER_OFF_BIT] |=> !recovered_receive_clock_out_buffer_off)
    else $error("buffer off with buffer bit clear");
  chk_squelch_reset_value: assert property (
    disable iff (1'b0) !nrst |=> s_r.squelch == rxcs_pkg::RST_SQUELCH_CTRL)
    else $error("squelch control reset value wrong");
  chk_status_read_clear: assert property (
    rd_acc && mgmt_reg_addr == rxcs_pkg::OFS_STAT_CLEAR_A |-> ##2 mgmt_rd_valid
    && mgmt_rd_data == $past(s_r.stat_a, 2) && s_r.stat_a == 16'h0000)
    else $error("clear-on-read status misbehaves");
  chk_release_on_good: assert property (
    link_good_s |-> !recovered_receive_clock_out_hold && !recovered_receive_clock_out_buffer_off)
    else $error("squelch not released on good link");
  chk_hold_needs_fault: assert property (
    !fault |=> !recovered_receive_clock_out_hold)
    else $error("clock held without fault");
  chk_buffer_needs_fault: assert property (
    !fault |=> !recovered_receive_clock_out_buffer_off)
    else $error("buffer off without fault");

  // register bus answer timing, readback, squelch write and status clear
  sequence read_answer_s;
    ##2 mgmt_rd_valid;
  endsequence

  sequence latch_read_s;
    rd_acc && mgmt_reg_addr == rxcs_pkg::OFS_STAT_LATCH;
  endsequence

  chk_read_answer_time: assert property (rd_acc |-> read_answer_s)
    else $error("read answer not two cycles after request");
  chk_read_valid_pulse: assert property (!$past(rd_acc, 2) |-> !mgmt_rd_valid)
    else $error("read answer without request");
  chk_squelch_readback: assert property (
    rd_acc && mgmt_reg_addr == rxcs_pkg::OFS_SQUELCH_CTRL
    |-> ##2 mgmt_rd_data == $past(s_r.squelch, 2))
    else $error("squelch control read back wrong");
  chk_squelch_write: assert property (
    wr_acc && mgmt_reg_addr == rxcs_pkg::OFS_SQUELCH_CTRL
    |=> s_r.squelch == ($past(mgmt_wr_data) & rxcs_pkg::MASK_SQUELCH_CTRL))
    else $error("squelch control write lost");
  chk_status_b_clear: assert property (
    rd_acc && mgmt_reg_addr == rxcs_pkg::OFS_STAT_CLEAR_B |=> s_r.stat_b == 16'h0000)
    else $error("second clear-on-read status not cleared");

  // fault latch and pin filter
  chk_latch_set_wins: assert property (fault |=> s_r.fault_latch)
    else $error("fault not latched");
  chk_latch_read_clear: assert property (latch_read_s ##0 !fault |=> !s_r.fault_latch)
    else $error("fault latch not cleared by read");
  chk_lock_filter_agree: assert property (
    $changed(s_r.lock_f) |-> $past(s_r.lock_sync[1]) == $past(s_r.lock_sync[2]))
    else $error("lock filter changed without agreement");
  chk_loss_filter_agree: assert property (
    $changed(s_r.sig_loss_f) |-> $past(s_r.sig_loss_sync[1]) == $past(s_r.sig_loss_sync[2]))
    else $error("loss filter changed without agreement");
endmodule

// *** testbench/recovered_receive_clock_out_fault_squelch_regs_tb_top.sv ***
// self-checking bench for the receive clock fault squelch register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module recovered_receive_clock_out_fault_squelch_regs_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] mgmt_dev_addr = rxcs_pkg::DEV_ADDR;
  logic [15:0] mgmt_reg_addr = 16'h0000;
  logic mgmt_wr_en = 1'b0;
  logic [15:0] mgmt_wr_data = 16'h0000;
  logic mgmt_rd_en = 1'b0;
  logic mgmt_rd_valid;
  logic [15:0] mgmt_rd_data;
  logic pll_lock = 1'b1;
  logic signal_lost = 1'b0;
  logic clock_hold;
  logic buffer_off;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycles = 0;
  logic [15:0] ofs [12] = '{16'h800b, 16'h800c, 16'h800d, 16'h800e, 16'h800f, 16'h8010,
    16'h8011, 16'h8012, 16'h8013, 16'h8015, 16'h8020, 16'h8021};
  logic [15:0] rst [12] = '{16'h013c, 16'h01bc, 16'h01fc, 16'h013c, 16'h01bc, 16'h01fc,
    16'h7f00, 16'hfffd, 16'hfffd, 16'h0000, 16'h0000, 16'h000f};

  rxcs_regs i_dut (
    .clock(clock),
    .nrst(nrst),
    .mgmt_dev_addr(mgmt_dev_addr),
    .mgmt_reg_addr(mgmt_reg_addr),
    .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wr_data(mgmt_wr_data),
    .mgmt_rd_en(mgmt_rd_en),
    .mgmt_rd_valid(mgmt_rd_valid),
    .mgmt_rd_data(mgmt_rd_data),
    .high_speed_side_pll_lock(pll_lock),
    .high_speed_side_loss_of_signal(signal_lost),
    .recovered_receive_clock_out_hold(clock_hold),
    .recovered_receive_clock_out_buffer_off(buffer_off)
  );

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic got);
    int i;
    @(posedge clock);
    #1;
    mgmt_reg_addr = a;
    mgmt_rd_en = 1'b1;
    @(posedge clock);
    #1;
    mgmt_rd_en = 1'b0;
    got = 1'b0;
    d = 16'h0000;
    for (i = 0; i < 4 && got == 1'b0; i++) begin
      if (mgmt_rd_valid === 1'b1) begin
        got = 1'b1;
        d = mgmt_rd_data;
      end else begin
        @(posedge clock);
        #1;
      end
    end
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic got;
    rd(a, d, got);
    `CHK(got, 1'b1)
    `CHK(d, exp)
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    mgmt_reg_addr = a;
    mgmt_wr_data = d;
    mgmt_wr_en = 1'b1;
    @(posedge clock);
    #1;
    mgmt_wr_en = 1'b0;
  endtask

  // pins pass a synchroniser and filter, so allow settling
  task automatic pins(input logic lock, input logic lost);
    pll_lock = lock;
    signal_lost = lost;
    repeat (10) @(posedge clock);
    #1;
  endtask

  initial begin
    logic [15:0] d;
    logic got;
    repeat (3) @(posedge clock);
    #1;
    nrst = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    for (int i = 0; i < 12; i++) begin
      chk_rd(ofs[i], rst[i]);
    end
    chk_rd(rxcs_pkg::OFS_STAT_CLEAR_A, 16'h0000);
    chk_rd(16'h8000, 16'h0000);
    $display("test reset values done");
    wr(rxcs_pkg::OFS_CTRL_A, 16'hffff);
    wr(rxcs_pkg::OFS_CTRL_G, 16'hffff);
    wr(rxcs_pkg::OFS_STAT_PLAIN, 16'hffff);
    chk_rd(rxcs_pkg::OFS_CTRL_A, 16'h03ff);
    chk_rd(rxcs_pkg::OFS_CTRL_G, 16'hff00);
    chk_rd(rxcs_pkg::OFS_STAT_PLAIN, 16'h0000);
    mgmt_dev_addr = 5'h01;
    rd(rxcs_pkg::OFS_SQUELCH_CTRL, d, got);
    `CHK(got, 1'b0)
    mgmt_dev_addr = rxcs_pkg::DEV_ADDR;
    $display("test access kinds done");
    wr(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h0063);
    chk_rd(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h0063);
    `CHK({clock_hold, buffer_off}, 2'b00)
    pins(1'b0, 1'b0);
    `CHK({clock_hold, buffer_off}, 2'b00)
    wr(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h006f);
    repeat (2) @(posedge clock);
    #1;
    `CHK({clock_hold, buffer_off}, 2'b11)
    pins(1'b0, 1'b0);
    `CHK({clock_hold, buffer_off}, 2'b11)
    chk_rd(rxcs_pkg::OFS_STAT_LATCH, 16'h0800);
    pins(1'b1, 1'b0);
    `CHK({clock_hold, buffer_off}, 2'b00)
    chk_rd(rxcs_pkg::OFS_STAT_LATCH, 16'h0900);
    chk_rd(rxcs_pkg::OFS_STAT_LATCH, 16'h0100);
    pins(1'b1, 1'b1);
    `CHK({clock_hold, buffer_off}, 2'b11)
    wr(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h0067);
    repeat (2) @(posedge clock);
    #1;
    `CHK({clock_hold, buffer_off}, 2'b01)
    wr(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h006b);
    repeat (2) @(posedge clock);
    #1;
    `CHK({clock_hold, buffer_off}, 2'b10)
    wr(rxcs_pkg::OFS_SQUELCH_CTRL, 16'h006f);
    pins(1'b1, 1'b0);
    `CHK({clock_hold, buffer_off}, 2'b00)
    $display("test fault response done");
    give_verdict();
  end
endmodule
